// ---- common/ppsc_pkg.sv ----
// package for the pin power state control block
package ppsc_pkg;

    // supply phase of the whole pin set
    typedef enum logic [1:0] {
        PhasePor,
        PhasePowerUp,
        PhasePowerDown
    } ppsc_phase_t;

    // state that one pad is put into
    typedef enum logic [2:0] {
        PadLow,
        PadHigh,
        PadPullDown,
        PadInput,
        PadFunc
    } ppsc_pad_t;

    localparam int MF_SEL_W = 32;
    localparam int GPIO_W = 7;
    localparam int CS_N = 3;
    localparam int MCS_N = 4;
    localparam int TEL_N = 4;
    localparam int SPI_N = 3;

    // select bit positions in the multi-function off-select word
    localparam int MF_TEL_FS = 31;
    localparam int MF_TEL_CLK = 30;
    localparam int MF_TEL_DOUT = 29;
    localparam int MF_TEL_DIN = 28;
    localparam int MF_DMA_REQ = 27;
    localparam int MF_DMA_GNT = 26;
    localparam int MF_SLOW_BUF = 25;
    localparam int MF_TXD = 24;
    localparam int MF_RXD = 23;
    localparam int MF_CS1 = 22;
    localparam int MF_MCS0 = 19;
    localparam int MF_SPI_CLK = 15;
    localparam int MF_CODEC_MCLK = 12;

    localparam logic [MF_SEL_W-1:0] MF_SEL_RST = 32'h0000_0000;
    localparam logic [GPIO_W-1:0] GPIO_SEL_RST = 7'h00;

    // pad states of the whole pin set
    typedef struct packed {
        ppsc_pad_t memPins;
        ppsc_pad_t readStrobe;
        ppsc_pad_t videoPins;
        ppsc_pad_t expSerialPins;
        ppsc_pad_t powerMgmtSelect;
        ppsc_pad_t bootSelect;
        ppsc_pad_t dmaGrant;
        ppsc_pad_t dmaRequest;
        ppsc_pad_t slowClockBuffer;
        ppsc_pad_t txd;
        ppsc_pad_t rxd;
        ppsc_pad_t [CS_N-1:0] chipSel;
        ppsc_pad_t [MCS_N-1:0] memCardSel;
        ppsc_pad_t [TEL_N-1:0] telecom;
        ppsc_pad_t [SPI_N-1:0] spi;
        ppsc_pad_t codecMclk;
        ppsc_pad_t codecOut;
        ppsc_pad_t codecIn;
        ppsc_pad_t mainSupplyPad;
        ppsc_pad_t plainInputs;
        ppsc_pad_t [GPIO_W-1:0] gpio;
    } ppsc_pads_t;

endpackage : ppsc_pkg

// ---- core/ppsc_phase_fsm.sv ----
// supply phase state machine
`timescale 1ns/1ps
`default_nettype none

module ppsc_phase_fsm
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic standbySupply,
    input wire logic mainSupplySense,
    input wire logic onButtonIn,
    input wire logic pwrOffCondition,
    output ppsc_pkg::ppsc_phase_t phase_ff
);

    ppsc_pkg::ppsc_phase_t nxt_phase;

    always_comb
    begin
        nxt_phase = phase_ff;
        case (phase_ff)
            ppsc_pkg::PhasePor:
            begin
                if (onButtonIn && mainSupplySense) // R3
                    nxt_phase = ppsc_pkg::PhasePowerUp;
            end
            ppsc_pkg::PhasePowerUp:
            begin
                if (pwrOffCondition)
                    nxt_phase = ppsc_pkg::PhasePowerDown;
            end
            ppsc_pkg::PhasePowerDown:
            begin
                if (!pwrOffCondition)
                    nxt_phase = ppsc_pkg::PhasePowerUp;
            end
            default:
            begin
                nxt_phase = ppsc_pkg::PhasePor;
            end
        endcase
        // standby lost: back to the first-power state
        if (!standbySupply) // R2
            nxt_phase = ppsc_pkg::PhasePor;
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            phase_ff <= ppsc_pkg::PhasePor; // R2
        else
            phase_ff <= nxt_phase; // R18
    end

endmodule : ppsc_phase_fsm

`default_nettype wire

// ---- core/ppsc_pad_control.sv ----
// pad state control for every external pin across the supply phases
// Contract
// R1 - power-off condition is the inverse of supply-on bit AND main supply sense.
// R2 - standby applied with main supply off puts all pins in reset state.
// R3 - on-button with main supply in reset state enters first power-up state.
// R4 - memory pins driven low in every phase, gated by memory pins-off bit; code drives them low in reset and power-down whatever the bit.
// R5 - read strobe low in reset, high at power-up, low when powered off.
// R6 - main oscillator runs only at power-up; slow oscillator always runs.
// R7 - video data and display control outputs low when video is disabled.
// R8 - power-management select low in reset and power-down, high at power-up.
// R9 - boot select pulled down in reset and power-down, high at power-up.
// R10 - dma grant low in reset, high at power-up, select bit 26 when off.
// R11 - selectable pins take their power-down state from their own select bit.
// R12 - telecom pins bits 31..28, serial peripheral 15..13, codec master clock 12.
// R13 - seven gpio pins pulled down in reset, input at power-up, own select bit.
// R14 - codec outputs always low; codec inputs pulled down except at power-up.
// R15 - power, button, reset and expansion interrupt pins always plain inputs.
// R16 - expansion serial clock and data low when that bus is disabled.
// R17 - main supply sense pulled down in reset and power-down, input at power-up.
// R18 - phase and pad states are registered on the single always-running clock.
// R19 - every power-down select bit has a defined reset value.
`timescale 1ns/1ps
`default_nettype none

module ppsc_pad_control
#(
    parameter int MF_W = ppsc_pkg::MF_SEL_W,
    parameter int GPIO_N = ppsc_pkg::GPIO_W
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic standbySupply,
    input wire logic mainSupplySense,
    input wire logic onButtonIn,
    input wire logic supplyOnBit,
    input wire logic memPinsOffBit,
    input wire logic videoDisabled,
    input wire logic expBusDisabled,
    input wire logic [MF_W-1:0] mfPinOffSelect,
    input wire logic [GPIO_N-1:0] gpioOffSelect,
    output ppsc_pkg::ppsc_phase_t phase,
    output logic pwrOffCondition,
    output logic mainOscEnable,
    output logic slowOscEnable,
    output ppsc_pkg::ppsc_pads_t padState
);

    // pick a pad state by phase
    function automatic ppsc_pkg::ppsc_pad_t byPhase(
        input ppsc_pkg::ppsc_phase_t ph,
        input ppsc_pkg::ppsc_pad_t porMode,
        input ppsc_pkg::ppsc_pad_t upMode,
        input ppsc_pkg::ppsc_pad_t downMode
    );
        ppsc_pkg::ppsc_pad_t r;
        r = porMode;
        case (ph)
            ppsc_pkg::PhasePor: r = porMode;
            ppsc_pkg::PhasePowerUp: r = upMode;
            ppsc_pkg::PhasePowerDown: r = downMode;
            default: r = porMode;
        endcase
        return r;
    endfunction : byPhase

    // selectable power-down state: set bit forces the off state, else pin keeps its up state
    function automatic ppsc_pkg::ppsc_pad_t offSel(
        input logic sel,
        input ppsc_pkg::ppsc_pad_t upMode,
        input ppsc_pkg::ppsc_pad_t offMode
    );
        return sel ? offMode : upMode;
    endfunction : offSel

    ppsc_pkg::ppsc_phase_t phaseNow;
    logic pwrOffNow;
    logic [MF_W-1:0] mfSel_ff;
    logic [GPIO_N-1:0] gpioSel_ff;
    logic pwrOff_ff;
    logic mainOsc_ff;
    logic slowOsc_ff;
    ppsc_pkg::ppsc_phase_t phaseOut_ff;
    ppsc_pkg::ppsc_pads_t pads_ff;
    ppsc_pkg::ppsc_pads_t nxt_pads;
    logic nxt_mainOsc;

    assign pwrOffNow = ~(supplyOnBit & mainSupplySense); // R1

    ppsc_phase_fsm u_phase
    (
        .mclk(mclk),
        .rst(rst),
        .standbySupply(standbySupply),
        .mainSupplySense(mainSupplySense),
        .onButtonIn(onButtonIn),
        .pwrOffCondition(pwrOffNow),
        .phase_ff(phaseNow)
    );

    // select words, defined before software sets them
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            mfSel_ff <= ppsc_pkg::MF_SEL_RST; // R19
            gpioSel_ff <= ppsc_pkg::GPIO_SEL_RST; // R19
        end
        else
        begin
            mfSel_ff <= mfPinOffSelect;
            gpioSel_ff <= gpioOffSelect;
        end
    end

    // per-pin decode
    wire ppsc_pkg::ppsc_pad_t memMode;
    wire ppsc_pkg::ppsc_pad_t readMode;
    wire ppsc_pkg::ppsc_pad_t videoMode;
    wire ppsc_pkg::ppsc_pad_t expMode;
    wire ppsc_pkg::ppsc_pad_t pmSelMode;
    wire ppsc_pkg::ppsc_pad_t bootMode;
    wire ppsc_pkg::ppsc_pad_t dmaGntMode;
    wire ppsc_pkg::ppsc_pad_t dmaReqMode;
    wire ppsc_pkg::ppsc_pad_t slowBufMode;
    wire ppsc_pkg::ppsc_pad_t txdMode;
    wire ppsc_pkg::ppsc_pad_t rxdMode;
    wire ppsc_pkg::ppsc_pad_t mclkMode;
    wire ppsc_pkg::ppsc_pad_t codecOutMode;
    wire ppsc_pkg::ppsc_pad_t codecInMode;
    wire ppsc_pkg::ppsc_pad_t supplyPadMode;
    wire ppsc_pkg::ppsc_pad_t plainInMode;
    wire logic phasePwrDown;

    assign phasePwrDown = (phaseNow == ppsc_pkg::PhasePowerDown) && pwrOffNow;

    // memory pins low outside power-up or when their off bit is set
    assign memMode = (memPinsOffBit || phaseNow != ppsc_pkg::PhasePowerUp) ?
        ppsc_pkg::PadLow : ppsc_pkg::PadFunc; // R4
    assign readMode = byPhase(phaseNow, ppsc_pkg::PadLow, ppsc_pkg::PadHigh,
        ppsc_pkg::PadLow); // R5
    assign videoMode = videoDisabled ? ppsc_pkg::PadLow : ppsc_pkg::PadFunc; // R7
    assign expMode = expBusDisabled ? ppsc_pkg::PadLow : ppsc_pkg::PadFunc; // R16
    assign pmSelMode = byPhase(phaseNow, ppsc_pkg::PadLow, ppsc_pkg::PadHigh,
        ppsc_pkg::PadLow); // R8
    assign bootMode = byPhase(phaseNow, ppsc_pkg::PadPullDown, ppsc_pkg::PadHigh,
        ppsc_pkg::PadPullDown); // R9
    assign dmaGntMode = byPhase(phaseNow, ppsc_pkg::PadLow, ppsc_pkg::PadHigh,
        offSel(mfSel_ff[ppsc_pkg::MF_DMA_GNT] && phasePwrDown, ppsc_pkg::PadHigh,
        ppsc_pkg::PadLow)); // R10
    assign dmaReqMode = byPhase(phaseNow, ppsc_pkg::PadPullDown, ppsc_pkg::PadInput,
        offSel(mfSel_ff[ppsc_pkg::MF_DMA_REQ], ppsc_pkg::PadInput,
        ppsc_pkg::PadPullDown)); // R11
    assign slowBufMode = byPhase(phaseNow, ppsc_pkg::PadPullDown, ppsc_pkg::PadInput,
        offSel(mfSel_ff[ppsc_pkg::MF_SLOW_BUF], ppsc_pkg::PadInput,
        ppsc_pkg::PadPullDown)); // R11
    assign txdMode = byPhase(phaseNow, ppsc_pkg::PadLow, ppsc_pkg::PadLow,
        offSel(mfSel_ff[ppsc_pkg::MF_TXD], ppsc_pkg::PadLow,
        ppsc_pkg::PadLow)); // R11
    assign rxdMode = byPhase(phaseNow, ppsc_pkg::PadPullDown, ppsc_pkg::PadInput,
        offSel(mfSel_ff[ppsc_pkg::MF_RXD], ppsc_pkg::PadInput,
        ppsc_pkg::PadPullDown)); // R11
    assign mclkMode = byPhase(phaseNow, ppsc_pkg::PadPullDown, ppsc_pkg::PadInput,
        offSel(mfSel_ff[ppsc_pkg::MF_CODEC_MCLK], ppsc_pkg::PadInput,
        ppsc_pkg::PadPullDown)); // R12
    assign codecOutMode = ppsc_pkg::PadLow; // R14
    assign codecInMode = byPhase(phaseNow, ppsc_pkg::PadPullDown, ppsc_pkg::PadInput,
        ppsc_pkg::PadPullDown); // R14
    assign supplyPadMode = byPhase(phaseNow, ppsc_pkg::PadPullDown, ppsc_pkg::PadInput,
        ppsc_pkg::PadPullDown); // R17
    assign plainInMode = ppsc_pkg::PadInput; // R15

    // replicated selectable groups
    wire ppsc_pkg::ppsc_pad_t [ppsc_pkg::CS_N-1:0] csMode;
    wire ppsc_pkg::ppsc_pad_t [ppsc_pkg::MCS_N-1:0] mcsMode;
    wire ppsc_pkg::ppsc_pad_t [ppsc_pkg::TEL_N-1:0] telMode;
    wire ppsc_pkg::ppsc_pad_t [ppsc_pkg::SPI_N-1:0] spiMode;
    wire ppsc_pkg::ppsc_pad_t [GPIO_N-1:0] gpioMode;

    genvar gi;
    generate
        for (gi = 0; gi < ppsc_pkg::CS_N; gi++)
        begin : g_cs
            // chip select 1 on the highest bit, downward
            assign csMode[gi] = byPhase(phaseNow, ppsc_pkg::PadPullDown, ppsc_pkg::PadHigh,
                offSel(mfSel_ff[ppsc_pkg::MF_CS1 - gi], ppsc_pkg::PadHigh,
                ppsc_pkg::PadPullDown)); // R11
        end
        for (gi = 0; gi < ppsc_pkg::MCS_N; gi++)
        begin : g_mcs
            assign mcsMode[gi] = byPhase(phaseNow, ppsc_pkg::PadPullDown, ppsc_pkg::PadInput,
                offSel(mfSel_ff[ppsc_pkg::MF_MCS0 - gi], ppsc_pkg::PadInput,
                ppsc_pkg::PadPullDown)); // R11
        end
        for (gi = 0; gi < ppsc_pkg::TEL_N; gi++)
        begin : g_tel
            // index 0 frame sync, 1 clock, 2 data out, 3 data in
            assign telMode[gi] = byPhase(phaseNow, ppsc_pkg::PadPullDown, ppsc_pkg::PadInput,
                offSel(mfSel_ff[ppsc_pkg::MF_TEL_FS - gi], ppsc_pkg::PadInput,
                ppsc_pkg::PadPullDown)); // R12
        end
        for (gi = 0; gi < ppsc_pkg::SPI_N; gi++)
        begin : g_spi
            // index 0 clock, 1 data out: driven low; index 2 data in: pulled down, input at power-up
            assign spiMode[gi] = (gi < 2) ?
                byPhase(phaseNow, ppsc_pkg::PadLow, ppsc_pkg::PadLow,
                    offSel(mfSel_ff[ppsc_pkg::MF_SPI_CLK - gi], ppsc_pkg::PadLow,
                    ppsc_pkg::PadLow)) :
                byPhase(phaseNow, ppsc_pkg::PadPullDown, ppsc_pkg::PadInput,
                    offSel(mfSel_ff[ppsc_pkg::MF_SPI_CLK - gi], ppsc_pkg::PadInput,
                    ppsc_pkg::PadPullDown)); // R12
        end
        for (gi = 0; gi < GPIO_N; gi++)
        begin : g_gpio
            assign gpioMode[gi] = byPhase(phaseNow, ppsc_pkg::PadPullDown, ppsc_pkg::PadInput,
                offSel(gpioSel_ff[gi], ppsc_pkg::PadInput,
                ppsc_pkg::PadPullDown)); // R13
        end
    endgenerate

    always_comb
    begin
        nxt_pads.memPins = memMode;
        nxt_pads.readStrobe = readMode;
        nxt_pads.videoPins = videoMode;
        nxt_pads.expSerialPins = expMode;
        nxt_pads.powerMgmtSelect = pmSelMode;
        nxt_pads.bootSelect = bootMode;
        nxt_pads.dmaGrant = dmaGntMode;
        nxt_pads.dmaRequest = dmaReqMode;
        nxt_pads.slowClockBuffer = slowBufMode;
        nxt_pads.txd = txdMode;
        nxt_pads.rxd = rxdMode;
        nxt_pads.chipSel = csMode;
        nxt_pads.memCardSel = mcsMode;
        nxt_pads.telecom = telMode;
        nxt_pads.spi = spiMode;
        nxt_pads.codecMclk = mclkMode;
        nxt_pads.codecOut = codecOutMode;
        nxt_pads.codecIn = codecInMode;
        nxt_pads.mainSupplyPad = supplyPadMode;
        nxt_pads.plainInputs = plainInMode;
        nxt_pads.gpio = gpioMode;
    end

    assign nxt_mainOsc = (phaseNow == ppsc_pkg::PhasePowerUp) && !pwrOffNow; // R6

    // reset value: every pin in its first-power state
    localparam ppsc_pkg::ppsc_pads_t PADS_RST = '{
        memPins: ppsc_pkg::PadLow,
        readStrobe: ppsc_pkg::PadLow,
        videoPins: ppsc_pkg::PadLow,
        expSerialPins: ppsc_pkg::PadLow,
        powerMgmtSelect: ppsc_pkg::PadLow,
        bootSelect: ppsc_pkg::PadPullDown,
        dmaGrant: ppsc_pkg::PadLow,
        dmaRequest: ppsc_pkg::PadPullDown,
        slowClockBuffer: ppsc_pkg::PadPullDown,
        txd: ppsc_pkg::PadLow,
        rxd: ppsc_pkg::PadPullDown,
        chipSel: '{ppsc_pkg::CS_N{ppsc_pkg::PadPullDown}},
        memCardSel: '{ppsc_pkg::MCS_N{ppsc_pkg::PadPullDown}},
        telecom: '{ppsc_pkg::TEL_N{ppsc_pkg::PadPullDown}},
        spi: '{ppsc_pkg::PadPullDown, ppsc_pkg::PadLow, ppsc_pkg::PadLow},
        codecMclk: ppsc_pkg::PadPullDown,
        codecOut: ppsc_pkg::PadLow,
        codecIn: ppsc_pkg::PadPullDown,
        mainSupplyPad: ppsc_pkg::PadPullDown,
        plainInputs: ppsc_pkg::PadInput,
        gpio: '{ppsc_pkg::GPIO_W{ppsc_pkg::PadPullDown}}
    };

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pads_ff <= PADS_RST; // R2
            pwrOff_ff <= 1'b1;
            mainOsc_ff <= 1'b0;
            slowOsc_ff <= 1'b1;
            phaseOut_ff <= ppsc_pkg::PhasePor;
        end
        else
        begin
            pads_ff <= nxt_pads; // R18
            pwrOff_ff <= pwrOffNow; // R1
            mainOsc_ff <= nxt_mainOsc; // R6
            slowOsc_ff <= 1'b1; // R6
            phaseOut_ff <= phaseNow;
        end
    end

    assign padState = pads_ff;
    assign pwrOffCondition = pwrOff_ff;
    assign mainOscEnable = mainOsc_ff;
    assign slowOscEnable = slowOsc_ff;
    assign phase = phaseOut_ff;

endmodule : ppsc_pad_control

`default_nettype wire

// ---- bench/ppsc_supply_model.sv ----
// supply and on-button model of the power management side
`timescale 1ns/1ps
`default_nettype none

module ppsc_supply_model
#(
    parameter int PRESS_LEN = 4
)
(
    input wire logic mclk,
    input wire logic standbyOn,
    input wire logic mainOn,
    input wire logic btnReq,
    output var logic standbySupply,
    output var logic mainSupplySense,
    output var logic onButtonIn
);
    int pressCnt;
    logic standbyReq = 1'b0;
    logic mainReq = 1'b0;
    logic btnLatch = 1'b0;
    initial
    begin
        standbySupply = 1'b0;
        mainSupplySense = 1'b0;
        onButtonIn = 1'b0;
        pressCnt = 0;
    end
    // requests taken at the rising edge, clear of the bench's falling-edge writes
    always @(posedge mclk)
    begin
        standbyReq <= standbyOn;
        mainReq <= mainOn;
        btnLatch <= btnReq;
    end
    // main supply cannot be up without standby
    always @(negedge mclk)
    begin
        standbySupply <= standbyReq;
        mainSupplySense <= mainReq && standbyReq;
        pressCnt <= btnLatch ? PRESS_LEN : (pressCnt > 0 ? pressCnt - 1 : 0);
        onButtonIn <= btnLatch || pressCnt > 1;
    end
endmodule : ppsc_supply_model
`default_nettype wire

// ---- bench/ppsc_pad_control_properties.sv ----
// concurrent checks on the pad control top ports
`timescale 1ns/1ps
`default_nettype none

module ppsc_pad_control_chk
#(
    parameter int MF_W = ppsc_pkg::MF_SEL_W,
    parameter int GPIO_N = ppsc_pkg::GPIO_W
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic standbySupply,
    input wire logic mainSupplySense,
    input wire logic onButtonIn,
    input wire logic supplyOnBit,
    input wire logic memPinsOffBit,
    input wire logic videoDisabled,
    input wire logic expBusDisabled,
    input wire logic [MF_W-1:0] mfPinOffSelect,
    input wire logic [GPIO_N-1:0] gpioOffSelect,
    input wire ppsc_pkg::ppsc_phase_t phase,
    input wire logic pwrOffCondition,
    input wire logic mainOscEnable,
    input wire logic slowOscEnable,
    input wire ppsc_pkg::ppsc_pads_t padState
);
    localparam ppsc_pkg::ppsc_pad_t LO = ppsc_pkg::PadLow;
    localparam ppsc_pkg::ppsc_pad_t PD = ppsc_pkg::PadPullDown;
    localparam ppsc_pkg::ppsc_phase_t POR = ppsc_pkg::PhasePor;
    localparam ppsc_pkg::ppsc_phase_t UP = ppsc_pkg::PhasePowerUp;
    localparam ppsc_pkg::ppsc_phase_t DN = ppsc_pkg::PhasePowerDown;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    property p_pwr_off;
        !$past(rst) |-> pwrOffCondition == !($past(supplyOnBit) && $past(mainSupplySense));
    endproperty
    a_pwr_off: assert property (p_pwr_off) else $error("power-off flag wrong");
    property p_standby;
        !standbySupply |-> ##2 phase == POR;
    endproperty
    a_standby: assert property (p_standby) else $error("no reset phase");
    property p_on_button;
        (phase == POR && onButtonIn && mainSupplySense && supplyOnBit && standbySupply)
            ##1 (mainSupplySense && supplyOnBit && standbySupply) |-> ##1 phase == UP;
    endproperty
    a_on_button: assert property (p_on_button) else $error("no power-up");
    property p_mem;
        (!$past(rst) && $past(memPinsOffBit)) || phase != UP |-> padState.memPins == LO;
    endproperty
    a_mem: assert property (p_mem) else $error("memory pins not low");
    property p_rd_low;
        phase == POR || (phase == DN && pwrOffCondition) |-> padState.readStrobe == LO;
    endproperty
    a_rd_low: assert property (p_rd_low) else $error("read strobe not low");
    property p_osc;
        slowOscEnable && mainOscEnable == (phase == UP && !pwrOffCondition);
    endproperty
    a_osc: assert property (p_osc) else $error("oscillator enable wrong");
    property p_boot;
        phase == POR || (phase == DN && pwrOffCondition) |-> padState.bootSelect == PD;
    endproperty
    a_boot: assert property (p_boot) else $error("boot select not pulled down");
    property p_sel_dma_request;
        phase == DN && pwrOffCondition && $past(pwrOffCondition) && $past(mfPinOffSelect[27], 2)
            |-> padState.dmaRequest == PD;
    endproperty
    a_sel_dma_request: assert property (p_sel_dma_request) else $error("dma request off state wrong");
    property p_sel_gpio;
        phase == DN && pwrOffCondition && $past(pwrOffCondition) && $past(gpioOffSelect[0], 2)
            |-> padState.gpio[0] == PD;
    endproperty
    a_sel_gpio: assert property (p_sel_gpio) else $error("gpio off state wrong");

    c_up: cover property (phase == UP);
    c_down: cover property (phase == DN);
    c_drop: cover property ($fell(standbySupply));
endmodule : ppsc_pad_control_chk

bind ppsc_pad_control ppsc_pad_control_chk #(.MF_W(MF_W), .GPIO_N(GPIO_N)) u_chk
(
    .mclk(mclk), .rst(rst), .standbySupply(standbySupply), .mainSupplySense(mainSupplySense),
    .onButtonIn(onButtonIn), .supplyOnBit(supplyOnBit), .memPinsOffBit(memPinsOffBit),
    .videoDisabled(videoDisabled), .expBusDisabled(expBusDisabled), .mfPinOffSelect(mfPinOffSelect),
    .gpioOffSelect(gpioOffSelect), .phase(phase), .pwrOffCondition(pwrOffCondition),
    .mainOscEnable(mainOscEnable), .slowOscEnable(slowOscEnable), .padState(padState)
);
`default_nettype wire

// ---- bench/ppsc_testbench.sv ----
// self-checking bench for the pad control block
`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam ppsc_pkg::ppsc_pad_t LO = ppsc_pkg::PadLow;
    localparam ppsc_pkg::ppsc_pad_t HI = ppsc_pkg::PadHigh;
    localparam ppsc_pkg::ppsc_pad_t PD = ppsc_pkg::PadPullDown;
    localparam ppsc_pkg::ppsc_pad_t IN = ppsc_pkg::PadInput;
    localparam ppsc_pkg::ppsc_pad_t FN = ppsc_pkg::PadFunc;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic supplyOnBit = 1'b0;
    logic memPinsOffBit = 1'b0;
    logic videoDisabled = 1'b0;
    logic expBusDisabled = 1'b0;
    logic [31:0] mfPinOffSelect = 32'h0000_0000;
    logic [6:0] gpioOffSelect = 7'h00;
    logic standbyOn = 1'b1;
    logic mainOn = 1'b0;
    logic btnReq = 1'b0;
    logic standbySupply;
    logic mainSupplySense;
    logic onButtonIn;
    ppsc_pkg::ppsc_phase_t phase;
    logic pwrOffCondition;
    logic mainOscEnable;
    logic slowOscEnable;
    ppsc_pkg::ppsc_pads_t padState;
    int fails = 0;
    int nChecks = 0;

    always #2.5 mclk = ~mclk;

    ppsc_supply_model model (.mclk(mclk), .standbyOn(standbyOn), .mainOn(mainOn), .btnReq(btnReq),
        .standbySupply(standbySupply), .mainSupplySense(mainSupplySense), .onButtonIn(onButtonIn));

    ppsc_pad_control dut (.mclk(mclk), .rst(rst), .standbySupply(standbySupply),
        .mainSupplySense(mainSupplySense), .onButtonIn(onButtonIn), .supplyOnBit(supplyOnBit),
        .memPinsOffBit(memPinsOffBit), .videoDisabled(videoDisabled), .expBusDisabled(expBusDisabled),
        .mfPinOffSelect(mfPinOffSelect), .gpioOffSelect(gpioOffSelect), .phase(phase),
        .pwrOffCondition(pwrOffCondition), .mainOscEnable(mainOscEnable), .slowOscEnable(slowOscEnable),
        .padState(padState));

    task automatic close_out();
        $display("checks %0d mismatches %0d", nChecks, fails);
        if (fails == 0 && nChecks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out

    task automatic chk(input logic [2:0] got, input logic [2:0] exp);
        nChecks++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_ph(input ppsc_pkg::ppsc_phase_t p);
        int i;
        for (i = 0; i < 40 && phase !== p; i++)
            @(negedge mclk);
        chk({1'b0, phase}, {1'b0, p});
    endtask : wait_ph

    // selectable pad behind one multi-function select bit
    function automatic ppsc_pkg::ppsc_pad_t pad_of(input int c);
        case (c)
            27: return padState.dmaRequest;
            26: return padState.dmaGrant;
            25: return padState.slowClockBuffer;
            24: return padState.txd;
            23: return padState.rxd;
            12: return padState.codecMclk;
            default: ;
        endcase
        if (c >= 28) return padState.telecom[31-c];
        if (c >= 20) return padState.chipSel[22-c];
        if (c >= 16) return padState.memCardSel[19-c];
        return padState.spi[15-c];
    endfunction : pad_of

    function automatic ppsc_pkg::ppsc_pad_t exp_of(input int c, input logic off);
        if (c == 24 || c == 15 || c == 14) return LO;
        if (c == 26) return off ? LO : HI;
        if (off) return PD;
        return (c >= 20 && c <= 22) ? HI : IN;
    endfunction : exp_of

    task automatic t_reset();
        chk({1'b0, phase}, {1'b0, ppsc_pkg::PhasePor});
        chk({2'b0, pwrOffCondition}, 3'h1);
        chk({1'b0, mainOscEnable, slowOscEnable}, 3'h1);
        chk(padState.readStrobe, LO);
        chk(padState.powerMgmtSelect, LO);
        chk(padState.bootSelect, PD);
        chk(padState.dmaGrant, LO);
        chk(padState.gpio[0], PD);
        chk(padState.mainSupplyPad, PD);
        chk(padState.codecIn, PD);
        chk(padState.plainInputs, IN);
        $display("reset test done");
    endtask : t_reset

    task automatic t_power_up();
        supplyOnBit = 1'b1;
        btnReq = 1'b1;
        @(negedge mclk);
        btnReq = 1'b0;
        repeat (10) @(negedge mclk);
        chk({1'b0, phase}, {1'b0, ppsc_pkg::PhasePor});
        mainOn = 1'b1;
        repeat (3) @(negedge mclk);
        chk({2'b0, pwrOffCondition}, 3'h0);
        btnReq = 1'b1;
        @(negedge mclk);
        btnReq = 1'b0;
        wait_ph(ppsc_pkg::PhasePowerUp);
        chk({2'b0, mainOscEnable}, 3'h1);
        chk(padState.readStrobe, HI);
        chk(padState.powerMgmtSelect, HI);
        chk(padState.bootSelect, HI);
        chk(padState.dmaGrant, HI);
        chk(padState.gpio[3], IN);
        chk(padState.mainSupplyPad, IN);
        chk(padState.codecIn, IN);
        chk(padState.codecOut, LO);
        mfPinOffSelect = 32'hffff_ffff;
        gpioOffSelect = 7'h7f;
        repeat (3) @(negedge mclk);
        chk(padState.dmaRequest, IN);
        chk(padState.gpio[6], IN);
        $display("power-up test done");
    endtask : t_power_up

    task automatic t_mem_video();
        int k;
        for (k = 0; k < 2; k++)
        begin
            memPinsOffBit = !k[0];
            videoDisabled = !k[0];
            expBusDisabled = !k[0];
            repeat (3) @(negedge mclk);
            chk(padState.memPins, k[0] ? FN : LO);
            chk(padState.videoPins, k[0] ? FN : LO);
            chk(padState.expSerialPins, k[0] ? FN : LO);
        end
        $display("memory and video test done");
    endtask : t_mem_video

    task automatic t_power_down();
        int b;
        int c;
        mainOn = 1'b0;
        wait_ph(ppsc_pkg::PhasePowerDown);
        chk({1'b0, pwrOffCondition, mainOscEnable}, 3'h2);
        chk(padState.readStrobe, LO);
        chk(padState.powerMgmtSelect, LO);
        chk(padState.bootSelect, PD);
        chk(padState.mainSupplyPad, PD);
        chk(padState.memPins, LO);
        for (b = 12; b < 32; b++)
        begin
            mfPinOffSelect = 32'h1 << b;
            gpioOffSelect = 7'(1 << (b % 7));
            repeat (3) @(negedge mclk);
            for (c = 12; c < 32; c++)
                chk(pad_of(c), exp_of(c, c == b));
            for (c = 0; c < 7; c++)
                chk(padState.gpio[c], c == b % 7 ? PD : IN);
        end
        mainOn = 1'b1;
        wait_ph(ppsc_pkg::PhasePowerUp);
        $display("power-down test done");
    endtask : t_power_down

    task automatic t_standby();
        standbyOn = 1'b0;
        wait_ph(ppsc_pkg::PhasePor);
        chk(padState.readStrobe, LO);
        chk(padState.bootSelect, PD);
        $display("standby test done");
    endtask : t_standby

    initial
    begin
        repeat (16) @(negedge mclk);
        t_reset();
        rst = 1'b0;
        t_power_up();
        t_mem_video();
        t_power_down();
        t_standby();
        close_out();
    end

    initial
    begin
        repeat (5000) @(posedge mclk);
        fails++;
        close_out();
    end
endmodule : testbench
`default_nettype wire
